//--- fbp_flash_block_protection.sv
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - 96 KB flash, erase acts on one 1-KB block
// - Erased block reads back all ones
// - Independent protection per 2-KB unit
// - Units open, read-only or execute-only
// - Read-only refuses erase and program, allows reads
// - Execute-only refuses erase and program
// - Execute-only readable by instruction fetch only
module fbp_flash_block_protection (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Access request and answer
  input wire fbp_pkg::fbp_req_t req,
  output logic reqReady,
  output var fbp_pkg::fbp_rsp_t rsp,
  // Block erase request
  input wire logic eraseValid,
  input wire logic [fbp_pkg::BLOCK_W-1:0] eraseBlock,
  output logic eraseDone,
  output logic eraseDenied,
  // Protection setup
  input wire logic protWrite,
  input wire logic [fbp_pkg::UNIT_W-1:0] protUnit,
  input wire logic [1:0] protMode,
  output logic [2*fbp_pkg::NUM_UNITS-1:0] protState
);
  import fbp_pkg::*;

  // Storage: one array of words, erase sweeps one block
  logic [DATA_W-1:0] flashMem [0:FLASH_BYTES/WORD_BYTES-1];

  logic [1:0] prot_q [0:NUM_UNITS-1];
  logic [1:0] prot_d [0:NUM_UNITS-1];
  fbp_state_t state_q, state_d;
  logic [BLOCK_W-1:0] eraseBlk_q, eraseBlk_d;
  logic [WIDX_W-1:0] eraseIdx_q, eraseIdx_d;
  fbp_rsp_t rsp_q, rsp_d;
  logic eraseDone_q, eraseDone_d;
  logic eraseDenied_q, eraseDenied_d;
  logic memWe;
  logic [ADDR_W-WORD_LSB-1:0] memWaddr;
  logic [DATA_W-1:0] memWdata;

  function automatic logic [UNIT_W-1:0] unitOfAddr(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:UNIT_LSB];
  endfunction : unitOfAddr

  function automatic logic [UNIT_W-1:0] unitOfBlock(input logic [BLOCK_W-1:0] b);
    return b[BLOCK_W-1:1];
  endfunction : unitOfBlock

  // Writes (erase or program) are allowed only in open units
  function automatic logic modifyOk(input logic [1:0] m);
    return m == PROT_OPEN;
  endfunction : modifyOk

  function automatic logic readOk(input logic [1:0] m, input fbp_op_t op);
    if (m == PROT_EXEC_ONLY) begin
      return op == FBP_OP_FETCH;
    end
    return 1'b1;
  endfunction : readOk

  // Address beyond the 96 KB array is treated as refused
  function automatic logic inRange(input logic [ADDR_W-1:0] a);
    return a < ADDR_W'(FLASH_BYTES);
  endfunction : inRange

  function automatic logic [ADDR_W-WORD_LSB-1:0] wordOfAddr(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:WORD_LSB];
  endfunction : wordOfAddr

  // Code 3 is reserved; a write carrying it leaves the unit alone
  function automatic logic modeLegal(input logic [1:0] m);
    return m != 2'h3;
  endfunction : modeLegal

  generate
    for (genvar u = 0; u < NUM_UNITS; u++) begin : g_prot
      always_comb begin
        prot_d[u] = prot_q[u];
        if (protWrite && protUnit == UNIT_W'(u) && modeLegal(protMode)) begin
          prot_d[u] = protMode;
        end
      end
      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          prot_q[u] <= PROT_OPEN;
        end else begin
          prot_q[u] <= prot_d[u];
        end
      end
      assign protState[2*u+1:2*u] = prot_q[u];
    end
  endgenerate

  // Shared request decode; indexes stay inside the unit table
  logic reqInRange;
  logic [1:0] reqMode;
  logic [ADDR_W-WORD_LSB-1:0] reqWord;
  logic eraseAllowed;
  logic progAllowed;
  logic readAllowed;

  always_comb begin
    reqInRange = inRange(req.addr);
    reqWord = wordOfAddr(req.addr);
    reqMode = PROT_OPEN;
    if (reqInRange) begin
      reqMode = prot_q[unitOfAddr(req.addr)];
    end
    // Blocks past the array are refused like protected ones
    eraseAllowed = 1'b0;
    if (eraseBlock < BLOCK_W'(NUM_BLOCKS)) begin
      eraseAllowed = modifyOk(prot_q[unitOfBlock(eraseBlock)]);
    end
    progAllowed = reqInRange && modifyOk(reqMode);
    readAllowed = reqInRange && readOk(reqMode, req.op);
  end

  always_comb begin
    state_d = state_q;
    eraseBlk_d = eraseBlk_q;
    eraseIdx_d = eraseIdx_q;
    rsp_d = rsp_q;
    rsp_d.done = 1'b0;
    eraseDone_d = 1'b0;
    eraseDenied_d = 1'b0;
    memWe = 1'b0;
    memWaddr = '0;
    memWdata = ERASED_WORD;
    case (state_q)
      FBP_IDLE: begin
        if (eraseValid) begin
          if (eraseAllowed) begin
            eraseBlk_d = eraseBlock;
            eraseIdx_d = '0;
            state_d = FBP_ERASE;
          end else begin
            eraseDone_d = 1'b1;
            eraseDenied_d = 1'b1;
          end
        end else if (req.valid) begin
          rsp_d.done = 1'b1;
          rsp_d.denied = 1'b0;
          rsp_d.rdata = DENIED_WORD;
          if (req.op == FBP_OP_PROG) begin
            if (progAllowed) begin
              memWe = 1'b1;
              memWaddr = reqWord;
              // Flash programming only clears bits
              memWdata = flashMem[reqWord] & req.wdata;
            end else begin
              rsp_d.denied = 1'b1;
            end
          end else if (readAllowed) begin
            rsp_d.rdata = flashMem[reqWord];
          end else begin
            rsp_d.denied = 1'b1;
          end
          state_d = FBP_RESP;
        end
      end
      FBP_ERASE: begin
        // One word per cycle; access requests wait meanwhile
        memWe = 1'b1;
        memWaddr = {eraseBlk_q, eraseIdx_q};
        memWdata = ERASED_WORD;
        eraseIdx_d = eraseIdx_q + WIDX_W'(1);
        if (eraseIdx_q == WIDX_W'(WORDS_PER_BLOCK - 1)) begin
          eraseDone_d = 1'b1;
          state_d = FBP_IDLE;
        end
      end
      FBP_RESP: begin
        // Gap cycle limits answers to one every two clocks
        state_d = FBP_IDLE;
      end
      default: begin
        state_d = FBP_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= FBP_IDLE;
      eraseBlk_q <= '0;
      eraseIdx_q <= '0;
      rsp_q <= '0;
      eraseDone_q <= 1'b0;
      eraseDenied_q <= 1'b0;
    end else begin
      state_q <= state_d;
      eraseBlk_q <= eraseBlk_d;
      eraseIdx_q <= eraseIdx_d;
      rsp_q <= rsp_d;
      eraseDone_q <= eraseDone_d;
      eraseDenied_q <= eraseDenied_d;
    end
  end

  // Array has no reset; contents survive like real flash
  always_ff @(posedge mclk) begin
    if (memWe) begin
      flashMem[memWaddr] <= memWdata;
    end
  end

  // Erase has priority; access waits while it runs
  assign reqReady = (state_q == FBP_IDLE) && !eraseValid;
  assign rsp = rsp_q;
  assign eraseDone = eraseDone_q;
  assign eraseDenied = eraseDenied_q;

endmodule : fbp_flash_block_protection

`default_nettype wire

//--- fbp_pkg.sv
package fbp_pkg;

  // Geometry
  localparam int unsigned FLASH_BYTES = 98304;
  localparam int unsigned BLOCK_BYTES = 1024;
  localparam int unsigned UNIT_BYTES = 2048;
  localparam int unsigned WORD_BYTES = 4;
  localparam int unsigned NUM_BLOCKS = FLASH_BYTES / BLOCK_BYTES;
  localparam int unsigned NUM_UNITS = FLASH_BYTES / UNIT_BYTES;
  localparam int unsigned WORDS_PER_BLOCK = BLOCK_BYTES / WORD_BYTES;
  localparam int unsigned ADDR_W = 17;
  localparam int unsigned BLOCK_LSB = 10;
  localparam int unsigned UNIT_LSB = 11;
  localparam int unsigned WORD_LSB = 2;
  localparam int unsigned BLOCK_W = 7;
  localparam int unsigned UNIT_W = 6;
  localparam int unsigned WIDX_W = 8;
  localparam int unsigned DATA_W = 32;

  // Erased flash reads as all ones
  localparam logic [DATA_W-1:0] ERASED_WORD = 32'hFFFFFFFF;
  localparam logic [DATA_W-1:0] DENIED_WORD = 32'h00000000;

  // Per-unit protection state encoding
  localparam logic [1:0] PROT_OPEN = 2'h0;
  localparam logic [1:0] PROT_READ_ONLY = 2'h1;
  localparam logic [1:0] PROT_EXEC_ONLY = 2'h2;

  typedef enum logic [3:0] {
    FBP_OP_FETCH = 4'h1,
    FBP_OP_DREAD = 4'h2,
    FBP_OP_DBGREAD = 4'h4,
    FBP_OP_PROG = 4'h8
  } fbp_op_t;

  typedef struct packed {
    logic valid;
    fbp_op_t op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } fbp_req_t;

  typedef struct packed {
    logic done;
    logic denied;
    logic [DATA_W-1:0] rdata;
  } fbp_rsp_t;

  typedef enum logic [2:0] {
    FBP_IDLE = 3'b001,
    FBP_ERASE = 3'b010,
    FBP_RESP = 3'b100
  } fbp_state_t;

endpackage : fbp_pkg

//--- fbp_checker_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module fbp_checker (
  // Watched ports
  input wire logic mclk,
  input wire logic sys_rst,
  input wire fbp_pkg::fbp_req_t req,
  input wire logic reqReady,
  input wire fbp_pkg::fbp_rsp_t rsp,
  input wire logic eraseValid,
  input wire logic [fbp_pkg::BLOCK_W-1:0] eraseBlock,
  input wire logic eraseDone,
  input wire logic eraseDenied,
  input wire logic protWrite,
  input wire logic [fbp_pkg::UNIT_W-1:0] protUnit,
  input wire logic [1:0] protMode,
  input wire logic [2*fbp_pkg::NUM_UNITS-1:0] protState
);
  import fbp_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic tk;
  logic [1:0] pm;
  logic [1:0] pe;
  assign tk = req.valid && reqReady && req.addr[16:15] != 2'h3;
  assign pm = protState[2*req.addr[16:11] +: 2];
  assign pe = protState[2*eraseBlock[6:1] +: 2];
  a_answer_pulse: assert property (req.valid && reqReady |=> rsp.done ##1 !rsp.done)
    else $error("answer pulse wrong");
  a_ro_prog_deny: assert property (tk && pm == PROT_READ_ONLY && req.op == FBP_OP_PROG |=> rsp.denied)
    else $error("read-only program taken");
  a_ro_read_ok: assert property (tk && pm == PROT_READ_ONLY && req.op != FBP_OP_PROG |=> !rsp.denied)
    else $error("read-only read denied");
  a_xo_nonfetch_deny: assert property (tk && pm == PROT_EXEC_ONLY && req.op != FBP_OP_FETCH |=> rsp.denied)
    else $error("exec-only access taken");
  a_xo_fetch_ok: assert property (tk && pm == PROT_EXEC_ONLY && req.op == FBP_OP_FETCH |=> !rsp.denied)
    else $error("exec-only fetch denied");
  a_deny_no_data: assert property (rsp.done && rsp.denied |-> rsp.rdata == DENIED_WORD)
    else $error("denied answer carries data");
  a_erase_refused: assert property (eraseValid && !$past(eraseValid) && $past(reqReady) && !$past(req.valid)
    && eraseBlock < NUM_BLOCKS && pe != PROT_OPEN |=> eraseDone && eraseDenied)
    else $error("protected erase not refused");
  a_erase_time: assert property (eraseValid && !$past(eraseValid) && $past(reqReady) && !$past(req.valid)
    && eraseBlock < NUM_BLOCKS && pe == PROT_OPEN |=> !eraseDone [*8] ##249 eraseDone && !eraseDenied)
    else $error("erase timing wrong");
  a_prot_store: assert property (protWrite && protUnit < NUM_UNITS && protMode != 2'h3
    |=> protState[2*$past(protUnit) +: 2] == $past(protMode))
    else $error("protection not stored");
endmodule : fbp_checker
bind fbp_flash_block_protection fbp_checker chk_i (.*);
`default_nettype wire

//--- fbp_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
module fbp_cpu_model (
  // Bench side
  input wire logic mclk,
  input wire logic go,
  input wire fbp_pkg::fbp_req_t cmd,
  // Flash side
  input wire logic reqReady,
  output var fbp_pkg::fbp_req_t req
);
  import fbp_pkg::*;
  initial req = '0;
  // Released lines flip so stale values never look valid
  always @(posedge mclk) begin
    if (req.valid && reqReady) req <= {1'b0, ~req[$bits(req)-2:0]};
    else if (go) req <= cmd;
  end
endmodule : fbp_cpu_model
`default_nettype wire

//--- testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import fbp_pkg::*;
  logic mclk = 0, sys_rst = 1, go = 0, reqReady, eraseValid = 0, eraseDone, eraseDenied, protWrite = 0;
  logic [BLOCK_W-1:0] eraseBlock = '0;
  logic [UNIT_W-1:0] protUnit = '0;
  logic [1:0] protMode = '0;
  logic [2*NUM_UNITS-1:0] protState;
  fbp_req_t cmd = '0, req;
  fbp_rsp_t rsp;
  int failures = 0, samples_checked = 0, k;
  logic [31:0] d;
  logic [16:0] a;
  always #4 mclk = ~mclk;
  fbp_cpu_model cpu (.*);
  fbp_flash_block_protection dut (.*);
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  task automatic waitf(input bit isErase, input int n);
    for (int i = 0; i < n && (isErase ? eraseDone : rsp.done) !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    if ((isErase ? eraseDone : rsp.done) !== 1'b1) begin
      failures++;
      end_sim;
    end
  endtask : waitf
  task automatic acc(fbp_op_t o, logic [16:0] ad, logic dn, logic [31:0] ed);
    @(posedge mclk);
    #1 cmd = '{1'b1, o, ad, d};
    go = 1;
    @(posedge mclk);
    #1 go = 0;
    waitf(1'b0, 20);
    chk("denied", 32'(dn), 32'(rsp.denied));
    chk("rdata", ed, rsp.rdata);
  endtask : acc
  task automatic ers(logic [6:0] b, logic dn);
    @(posedge mclk);
    #1 eraseValid = 1;
    eraseBlock = b;
    waitf(1'b1, 300);
    // Drop now, a held request would restart
    eraseValid = 0;
    chk("eraseDenied", 32'(dn), 32'(eraseDenied));
  endtask : ers
  task automatic setp(logic [5:0] u, logic [1:0] m, logic [1:0] e);
    @(posedge mclk);
    #1 protWrite = 1;
    protUnit = u;
    protMode = m;
    @(posedge mclk);
    #1 protWrite = 0;
    chk("protState", 32'(e), 32'(protState[2*u +: 2]));
  endtask : setp
  initial begin
    void'($urandom(71));
    repeat (2) @(posedge mclk);
    #1 sys_rst = 0;
    for (k = 0; k < 4; k++) begin
      a = 17'($urandom_range(98303)) & 17'h1FFFC;
      d = $urandom;
      ers(a[16:10], 0);
      acc(FBP_OP_DREAD, a, 0, ERASED_WORD);
      acc(FBP_OP_PROG, a, 0, 0);
      setp(a[16:11], PROT_READ_ONLY, PROT_READ_ONLY);
      acc(FBP_OP_PROG, a, 1, 0);
      ers(a[16:10], 1);
      ers(a[16:10] ^ 7'h02, 0);
      acc(FBP_OP_DBGREAD, a, 0, d);
      setp(a[16:11], PROT_EXEC_ONLY, PROT_EXEC_ONLY);
      setp(a[16:11], 2'h3, PROT_EXEC_ONLY);
      acc(FBP_OP_FETCH, a, 0, d);
      acc(FBP_OP_DREAD, a, 1, 0);
      acc(FBP_OP_DBGREAD, a, 1, 0);
      acc(FBP_OP_PROG, a, 1, 0);
      ers(a[16:10], 1);
      acc(FBP_OP_FETCH, a, 0, d);
      setp(a[16:11], PROT_OPEN, PROT_OPEN);
      $display("test %0d done", k);
    end
    ers(7'h60, 1);
    setp(6'h00, PROT_READ_ONLY, PROT_READ_ONLY);
    @(posedge mclk);
    #1 sys_rst = 1;
    repeat (2) @(posedge mclk);
    #1 sys_rst = 0;
    chk("protReset", 0, 32'(|protState));
    acc(FBP_OP_DREAD, 17'h18000, 1, 0);
    end_sim;
  end
endmodule : testbench
`default_nettype wire
